// file: iex_consts.svh
// Purpose: shared constants of the integer execution datapath
// Assumes: included by its bare name
// Notes:   cycle counts are in pipeline clocks
`ifndef IEX_CONSTS_SVH
`define IEX_CONSTS_SVH
// ----------------------------------------
// widths
// ----------------------------------------
`define XLEN       32
`define REG_IDX_W  5
// ----------------------------------------
// multiplier pass widths
// ----------------------------------------
`define MUL_B_HALF 16
// ----------------------------------------
// divide early-in skips and busy counts
// ----------------------------------------
`define SKIP_B8    6'h17
`define SKIP_B16   6'h0F
`define SKIP_B24   6'h07
`define SKIP_NONE  6'h00
`define DIV_RPT_B8  6'h0B
`define DIV_RPT_B16 6'h12
`define DIV_RPT_B24 6'h19
`define DIV_RPT_B32 6'h20
`endif

// file: iex_pkg.sv
// Purpose: types of the integer execution datapath
// Assumes: nothing
// Notes:   opUnsigned travels beside the operation code
package iex_pkg;
	// operations issued by the integer pipeline
	typedef enum logic [4:0] {
		OP_NOP, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_NOR,
		OP_SLL, OP_SRL, OP_SRA, OP_SLT, OP_LEADZ, OP_LEADO,
		OP_RDUPPER, OP_RDBOTTOM,
		OP_MPAIR, OP_MACC, OP_MDED, OP_MGPR, OP_DIV
	} op_t;
endpackage

// file: integer_exec_mul_div.sv
// Purpose: integer execution datapath with product/quotient unit
// Assumes: one clock ref_clk; the integer pipeline holds its request while stall is high
// Notes:
`include "iex_consts.svh"
module integer_exec_mul_div #(
	parameter int SETS = 2                    // register sets, main plus shadow
) (
	input  wire logic                  ref_clk,
	input  wire logic                  resetn,
	input  wire logic                  opValid,     // request from the pipeline
	input  wire iex_pkg::op_t          opCode,      // operation
	input  wire logic                  opUnsigned,  // unsigned compare/multiply/divide
	input  wire logic [4:0]            srcA,        // left operand register
	input  wire logic [4:0]            srcB,        // right operand register
	input  wire logic [4:0]            dest,        // destination register
	input  wire logic                  shadowSel,   // use the shadow set
	output logic                       stall,       // request not taken this cycle
	output logic                       wbValid,     // write-back this cycle
	output logic [5:0]                 wbDest,      // {set, register}
	output logic [`XLEN-1:0]           wbData       // write-back data
);
	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic [`XLEN-1:0] gpr_ff [0:SETS*32-1];  // general registers, both sets
	logic             wbValid_ff;              // write-back stage
	logic [5:0]       wbDest_ff;
	logic [31:0]      wbData_ff;
	logic [31:0]      upperResult_ff;          // upper result register
	logic [31:0]      bottomResult_ff;         // bottom result register
	logic             pass2Busy_ff;            // second multiplier pass pending
	iex_pkg::op_t     p2Op_ff;                 // kind of the pending full multiply
	logic [5:0]       p2Dest_ff;
	logic [32:0]      p2A_ff;                  // left operand, extended
	logic [16:0]      p2BHigh_ff;              // upper half of right operand
	logic [63:0]      partial_ff;              // first pass product
	logic             gprValid_ff;             // register multiply result stage
	logic [5:0]       gprDest_ff;
	logic [31:0]      gprData_ff;
	logic [5:0]       divCount_ff;             // divide busy count
	logic [5:0]       divIter_ff;              // iterations of this divide
	logic [32:0]      divRem_ff;
	logic [31:0]      divQuo_ff;
	logic [31:0]      divDvs_ff;               // divisor magnitude
	logic             divNegQ_ff;
	logic             divNegR_ff;
	logic [31:0]      leftOperand, rightOperand;
	logic             isProdOp, isRead, aluWrite, accept;
	logic             rightShort;
	logic [32:0]      aExt;
	logic [16:0]      bLow;
	logic signed [49:0] pass1, pass2;
	logic [63:0]      prod1, prodFull, pairBase;
	logic [31:0]      aluRes;
	logic [32:0]      divShift, divRemN;
	logic             divGe, divIterNow, divFinish;
	logic [31:0]      divQuoN, divQuoFix, divRemFix;
	logic [5:0]       divSkip, divRpt;
	logic [31:0]      aMag, bMag;

	// ----------------------------------------
	// functions
	// ----------------------------------------
	// true when v is the extension of its low bits
	function automatic logic fitsIn(input logic [31:0] v, input int bits, input logic uns);
		logic [31:0] upperBits;
		upperBits = uns ? (v >> bits) : 32'($signed(v) >>> (bits - 1));
		fitsIn = (upperBits == 32'h0) || (!uns && upperBits == 32'hFFFFFFFF);
	endfunction

	// operand read with bypass from the write-back stage
	function automatic logic [31:0] rdPort(input logic [5:0] a);
		if (a[4:0] == 5'h00) begin
			rdPort = 32'h0;                      // register zero reads zero
		end else if (wbValid_ff && wbDest_ff == a) begin
			rdPort = wbData_ff;
		end else begin
			rdPort = gpr_ff[a];
		end
	endfunction

	// count of leading bits equal to ones
	function automatic logic [31:0] leadCount(input logic [31:0] v, input logic ones);
		logic stop;
		leadCount = 32'h0;
		stop = 1'b0;
		for (int i = 31; i >= 0; i--) begin
			if (v[i] != ones) stop = 1'b1;
			if (!stop) leadCount = leadCount + 32'h1;
		end
	endfunction

	// fold a product into the result pair
	function automatic logic [63:0] applyMul(input iex_pkg::op_t k, input logic [63:0] b,
			input logic [63:0] p);
		case (k)
			iex_pkg::OP_MACC: applyMul = b + p;
			iex_pkg::OP_MDED: applyMul = b - p;
			default:          applyMul = p;
		endcase
	endfunction

	// ----------------------------------------
	// operand read and issue control
	// ----------------------------------------
	assign leftOperand  = rdPort({shadowSel, srcA});
	assign rightOperand = rdPort({shadowSel, srcB});
	assign isProdOp = opCode inside {iex_pkg::OP_MPAIR, iex_pkg::OP_MACC, iex_pkg::OP_MDED,
		iex_pkg::OP_MGPR, iex_pkg::OP_DIV};
	assign isRead = opCode inside {iex_pkg::OP_RDUPPER, iex_pkg::OP_RDBOTTOM};
	assign aluWrite = !isProdOp && opCode != iex_pkg::OP_NOP;

	// stall reasons; the product unit's own state never waits on stall
	always_comb begin
		stall = 1'b0;
		if (opValid) begin
			if (isProdOp && (pass2Busy_ff || divCount_ff > 6'h01)) stall = 1'b1;
			if (isRead && (pass2Busy_ff || divCount_ff != 6'h00)) stall = 1'b1;
			// one write port: the register multiply stage owns it this cycle
			if (aluWrite && gprValid_ff) stall = 1'b1;
			// operand not yet produced by a register multiply
			if ((gprValid_ff && (gprDest_ff == {shadowSel, srcA} ||
					gprDest_ff == {shadowSel, srcB})) ||
				(pass2Busy_ff && p2Op_ff == iex_pkg::OP_MGPR &&
					(p2Dest_ff == {shadowSel, srcA} || p2Dest_ff == {shadowSel, srcB})))
				stall = 1'b1;
		end
	end
	assign accept = opValid && !stall;

	// ----------------------------------------
	// single-cycle ALU and leading count
	// ----------------------------------------
	always_comb begin
		case (opCode)
			iex_pkg::OP_ADD:      aluRes = leftOperand + rightOperand;
			iex_pkg::OP_SUB:      aluRes = leftOperand - rightOperand;
			iex_pkg::OP_AND:      aluRes = leftOperand & rightOperand;
			iex_pkg::OP_OR:       aluRes = leftOperand | rightOperand;
			iex_pkg::OP_XOR:      aluRes = leftOperand ^ rightOperand;
			iex_pkg::OP_NOR:      aluRes = ~(leftOperand | rightOperand);
			iex_pkg::OP_SLL:      aluRes = leftOperand << rightOperand[4:0];
			iex_pkg::OP_SRL:      aluRes = leftOperand >> rightOperand[4:0];
			iex_pkg::OP_SRA:      aluRes = 32'($signed(leftOperand) >>> rightOperand[4:0]);
			iex_pkg::OP_SLT:      aluRes = {31'h0, opUnsigned ? leftOperand < rightOperand :
				$signed(leftOperand) < $signed(rightOperand)};
			iex_pkg::OP_LEADZ:    aluRes = leadCount(leftOperand, 1'b0);
			iex_pkg::OP_LEADO:    aluRes = leadCount(leftOperand, 1'b1);
			iex_pkg::OP_RDUPPER:  aluRes = upperResult_ff;
			iex_pkg::OP_RDBOTTOM: aluRes = bottomResult_ff;
			default:              aluRes = 32'h0;
		endcase
	end

	// ----------------------------------------
	// multiplier, 33x17 signed per pass
	// ----------------------------------------
	// size is seen from the right operand only, no software hint
	assign rightShort = fitsIn(rightOperand, `MUL_B_HALF, opUnsigned);
	assign aExt  = {!opUnsigned & leftOperand[31], leftOperand};
	// a short operand carries its own sign in the single pass
	assign bLow  = {rightShort & !opUnsigned & rightOperand[15], rightOperand[15:0]};
	assign pass1 = $signed(aExt) * $signed(bLow);
	assign prod1 = {{14{pass1[49]}}, pass1};
	assign pass2 = $signed(p2A_ff) * $signed(p2BHigh_ff);
	assign prodFull = partial_ff + {pass2[47:0], 16'h0};
	// a divide ending this cycle is the base an accumulate sees
	assign pairBase = divFinish ? {divRemFix, divQuoFix} : {upperResult_ff, bottomResult_ff};

	// second pass bookkeeping
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pass2Busy_ff <= 1'b0;
			p2Op_ff      <= iex_pkg::OP_NOP;
			p2Dest_ff    <= 6'h00;
			p2A_ff       <= 33'h0;
			p2BHigh_ff   <= 17'h0;
			partial_ff   <= 64'h0;
		end else begin
			pass2Busy_ff <= 1'b0;
			if (accept && isProdOp && opCode != iex_pkg::OP_DIV && !rightShort) begin
				pass2Busy_ff <= 1'b1;
				p2Op_ff      <= opCode;
				p2Dest_ff    <= {shadowSel, dest};
				p2A_ff       <= aExt;
				p2BHigh_ff   <= {!opUnsigned & rightOperand[31], rightOperand[31:16]};
				partial_ff   <= prod1;
			end
		end
	end

	// register multiply result stage, one clock before write-back
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			gprValid_ff <= 1'b0;
			gprDest_ff  <= 6'h00;
			gprData_ff  <= 32'h0;
		end else begin
			gprValid_ff <= 1'b0;
			if (pass2Busy_ff && p2Op_ff == iex_pkg::OP_MGPR) begin
				gprValid_ff <= 1'b1;
				gprDest_ff  <= p2Dest_ff;
				gprData_ff  <= prodFull[31:0];
			end else if (accept && opCode == iex_pkg::OP_MGPR && rightShort) begin
				gprValid_ff <= 1'b1;
				gprDest_ff  <= {shadowSel, dest};
				gprData_ff  <= prod1[31:0];
			end
		end
	end

	// upper and bottom result registers
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			upperResult_ff  <= 32'h0;
			bottomResult_ff <= 32'h0;
		end else if (pass2Busy_ff && p2Op_ff != iex_pkg::OP_MGPR) begin
			{upperResult_ff, bottomResult_ff} <= applyMul(p2Op_ff, pairBase, prodFull);
		end else if (accept && rightShort && opCode inside {iex_pkg::OP_MPAIR,
				iex_pkg::OP_MACC, iex_pkg::OP_MDED}) begin
			{upperResult_ff, bottomResult_ff} <= applyMul(opCode, pairBase, prod1);
		end else if (divFinish) begin
			upperResult_ff  <= divRemFix;
			bottomResult_ff <= divQuoFix;
		end
	end

	// ----------------------------------------
	// divider, restoring, one bit per clock
	// ----------------------------------------
	assign divShift   = {divRem_ff[31:0], divQuo_ff[31]};
	assign divGe      = divShift >= {1'b0, divDvs_ff};
	assign divRemN    = divGe ? divShift - {1'b0, divDvs_ff} : divShift;
	assign divQuoN    = {divQuo_ff[30:0], divGe};
	assign divIterNow = divCount_ff != 6'h00 && divCount_ff <= divIter_ff;
	assign divFinish  = divCount_ff == 6'h01;
	assign divQuoFix  = divNegQ_ff ? 32'h0 - divQuoN : divQuoN;
	assign divRemFix  = divNegR_ff ? 32'h0 - divRemN[31:0] : divRemN[31:0];
	assign aMag = (!opUnsigned && leftOperand[31]) ? 32'h0 - leftOperand : leftOperand;
	assign bMag = (!opUnsigned && rightOperand[31]) ? 32'h0 - rightOperand : rightOperand;

	// early-in: sign extension (zero extension when unsigned) of the dividend picks the skip
	always_comb begin
		if (fitsIn(leftOperand, 8, opUnsigned)) begin
			divSkip = `SKIP_B8;
			divRpt  = `DIV_RPT_B8;
		end else if (fitsIn(leftOperand, 16, opUnsigned)) begin
			divSkip = `SKIP_B16;
			divRpt  = `DIV_RPT_B16;
		end else if (fitsIn(leftOperand, 24, opUnsigned)) begin
			divSkip = `SKIP_B24;
			divRpt  = `DIV_RPT_B24;
		end else begin
			divSkip = `SKIP_NONE;
			divRpt  = `DIV_RPT_B32;
		end
	end

	// divide state; a new divide may load in the finishing cycle
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			divCount_ff <= 6'h00;
			divIter_ff  <= 6'h00;
			divRem_ff   <= 33'h0;
			divQuo_ff   <= 32'h0;
			divDvs_ff   <= 32'h0;
			divNegQ_ff  <= 1'b0;
			divNegR_ff  <= 1'b0;
		end else if (accept && opCode == iex_pkg::OP_DIV) begin
			divCount_ff <= divRpt;
			divIter_ff  <= 6'h20 - divSkip;
			divRem_ff   <= 33'h0;
			divQuo_ff   <= aMag << divSkip;
			divDvs_ff   <= bMag;
			divNegQ_ff  <= !opUnsigned && (leftOperand[31] ^ rightOperand[31]);
			divNegR_ff  <= !opUnsigned && leftOperand[31];
		end else if (divCount_ff != 6'h00) begin
			divCount_ff <= divCount_ff - 6'h01;
			if (divIterNow) begin
				divRem_ff <= divRemN;
				divQuo_ff <= divQuoN;
			end
		end
	end

	// ----------------------------------------
	// write-back and register file
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			wbValid_ff <= 1'b0;
			wbDest_ff  <= 6'h00;
			wbData_ff  <= 32'h0;
		end else if (gprValid_ff) begin
			wbValid_ff <= 1'b1;
			wbDest_ff  <= gprDest_ff;
			wbData_ff  <= gprData_ff;
		end else begin
			wbValid_ff <= accept && aluWrite;
			wbDest_ff  <= {shadowSel, dest};
			wbData_ff  <= aluRes;
		end
	end

	// storage for both sets; contents need no reset
	always_ff @(posedge ref_clk) begin
		if (wbValid_ff && wbDest_ff[4:0] != 5'h00) begin
			gpr_ff[wbDest_ff] <= wbData_ff;
		end
	end
	assign wbValid = wbValid_ff;
	assign wbDest  = wbDest_ff;
	assign wbData  = wbData_ff;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	a_short_pair_one: assert property (accept && opCode == iex_pkg::OP_MPAIR && rightShort
		|=> !pass2Busy_ff && {upperResult_ff, bottomResult_ff} == $past(prod1))
		else $error("short pair multiply not done in one clock");
	a_full_two_pass: assert property (accept && opCode == iex_pkg::OP_MPAIR && !rightShort
		|=> pass2Busy_ff ##1 !pass2Busy_ff)
		else $error("full multiply pass count wrong");
	a_full_b2b_stall: assert property (pass2Busy_ff && opValid && isProdOp |-> stall)
		else $error("back to back full multiply not stalled");
	a_div_busy_stall: assert property (divCount_ff > 6'h01 && opValid && isProdOp |-> stall)
		else $error("product op issued during divide");
	a_div_b8_latency: assert property (accept && opCode == iex_pkg::OP_DIV &&
		divSkip == `SKIP_B8 |=> divCount_ff == 6'h0B ##10 divFinish)
		else $error("short divide latency wrong");
	a_read_early_stall: assert property (opValid && isRead &&
		divCount_ff != 6'h00 |-> stall)
		else $error("result register read before divide end");
	a_alu_one_cycle: assert property (accept && aluWrite && !gprValid_ff
		|=> wbValid_ff && wbData_ff == $past(aluRes))
		else $error("alu result not written next clock");
	a_bypass_read: assert property (wbValid_ff && wbDest_ff == {shadowSel, srcA} &&
		srcA != 5'h00 |-> leftOperand == wbData_ff)
		else $error("bypass missed");
	a_mgpr_short_lat: assert property (accept && opCode == iex_pkg::OP_MGPR && rightShort
		|=> gprValid_ff ##1 wbValid_ff && wbData_ff == $past(prod1[31:0], 2))
		else $error("register multiply latency wrong");
	a_lead_zero_all: assert property (accept && opCode == iex_pkg::OP_LEADZ &&
		leftOperand == 32'h0 && !gprValid_ff |=> wbData_ff == 32'h20)
		else $error("leading zero count of zero wrong");
	c_short_mul: cover property (accept && opCode == iex_pkg::OP_MACC && rightShort);
	c_full_mul:  cover property (accept && opCode == iex_pkg::OP_MGPR && !rightShort);
	c_div_b8:    cover property (accept && opCode == iex_pkg::OP_DIV && divSkip == `SKIP_B8);
	c_read_wait: cover property (opValid && isRead && stall);
endmodule

// file: integer_exec_mul_div_bench.sv
// Purpose: self-checking bench of the integer execution block
// Assumes: 40 ns clock; write-backs come back in the order they were taken
// Notes:   register values are built from r0 by ALU ops, there is no load port
`define CHK(got, exp) begin numChecks++; if ((got) !== (exp)) begin errTotal++; \
	$display("mismatch at %0t got %0h expected %0h", $time, (got), (exp)); end end
module integer_exec_mul_div_bench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [5:0] d; logic [31:0] v; time due;} exp_t;
	logic         ref_clk;    // pipeline clock
	logic         resetn;     // async reset, active low
	logic         opValid;    // request lines from the pipeline model
	iex_pkg::op_t opCode;
	logic         opUnsigned;
	logic [4:0]   srcA;
	logic [4:0]   srcB;
	logic [4:0]   dest;
	logic         shadowSel;
	logic         stall;      // refusal from the block
	logic         wbValid;    // write-back pulse
	logic [5:0]   wbDest;
	logic [31:0]  wbData;
	int           errTotal;   // mismatches seen
	int           numChecks;  // comparisons made
	exp_t         expQ[$];    // write-backs still owed
	time          t0;         // take edge of the last product/quotient op
	time          t1;
	// ----------------------------------------
	// instances
	// ----------------------------------------
	integer_exec_mul_div i_dut (.ref_clk(ref_clk), .resetn(resetn), .opValid(opValid),
		.opCode(opCode), .opUnsigned(opUnsigned), .srcA(srcA), .srcB(srcB), .dest(dest),
		.shadowSel(shadowSel), .stall(stall), .wbValid(wbValid), .wbDest(wbDest),
		.wbData(wbData));
	pipe_issuer i_pipe (.ref_clk(ref_clk), .stall(stall), .opValid(opValid), .opCode(opCode),
		.opUnsigned(opUnsigned), .srcA(srcA), .srcB(srcB), .dest(dest), .shadowSel(shadowSel));
	// ----------------------------------------
	// clock and write-back monitor
	// ----------------------------------------
	initial ref_clk = 1'b0;
	always #20 ref_clk = ~ref_clk;
	// every pulse must match the oldest owed write-back, in place and time
	always @(posedge ref_clk) begin
		if (wbValid === 1'b1) begin
			if (expQ.size() == 0) `CHK(wbValid, 1'b0)
			else begin
				`CHK(wbDest, expQ[0].d)
				`CHK(wbData, expQ[0].v)
				`CHK($time, expQ[0].due)
				void'(expQ.pop_front());
			end
		end
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// op that writes a register: the owed write-back is queued at its take edge
	task automatic op(input iex_pkg::op_t c, input logic u, input logic [4:0] a, b, d,
		input logic sh, input logic [31:0] v, input int lat);
		i_pipe.issue(c, u, a, b, d, sh);
		expQ.push_back('{{sh, d}, v, i_pipe.lastTake + lat * 40});
	endtask
	// op that only touches the result pair
	task automatic prodOp(input iex_pkg::op_t c, input logic u, input logic [4:0] a, b);
		i_pipe.issue(c, u, a, b, 5'h00, 1'b0);
		t0 = i_pipe.lastTake;
	endtask
	// result read, judged by value and by clocks since the last product op
	task automatic rd(input iex_pkg::op_t c, input logic [31:0] v, input int dt);
		op(c, 1'b0, 5'h00, 5'h00, 5'h0C, 1'b0, v, 1);
		`CHK((i_pipe.lastTake - t0) / 40, dt)
	endtask
	task automatic drain();
		int n;
		i_pipe.idle();
		for (n = 0; n < 8 && expQ.size() != 0; n++) begin
			@(posedge ref_clk);
		end
		`CHK(expQ.size(), 0)
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	// ops 2 to 6 and the SRA each read the previous result at once, so the bypass is in use
	task automatic aluSeq();
		op(iex_pkg::OP_NOR, 0, 0, 0, 1, 0, 32'hFFFFFFFF, 1);
		op(iex_pkg::OP_SUB, 0, 0, 1, 2, 0, 32'h00000001, 1);
		op(iex_pkg::OP_ADD, 0, 2, 2, 3, 0, 32'h00000002, 1);
		op(iex_pkg::OP_ADD, 0, 3, 3, 4, 0, 32'h00000004, 1);
		op(iex_pkg::OP_SLL, 0, 2, 4, 5, 0, 32'h00000010, 1);
		op(iex_pkg::OP_SLL, 0, 2, 5, 6, 0, 32'h00010000, 1);
		op(iex_pkg::OP_SRL, 0, 1, 2, 7, 0, 32'h7FFFFFFF, 1);
		op(iex_pkg::OP_SLL, 0, 5, 4, 8, 0, 32'h00000100, 1);
		op(iex_pkg::OP_XOR, 0, 1, 7, 11, 0, 32'h80000000, 1);
		op(iex_pkg::OP_SRA, 0, 11, 4, 9, 0, 32'hF8000000, 1);
		op(iex_pkg::OP_AND, 0, 1, 7, 9, 0, 32'h7FFFFFFF, 1);
		op(iex_pkg::OP_OR, 0, 5, 2, 9, 0, 32'h00000011, 1);
		op(iex_pkg::OP_SLT, 0, 1, 2, 9, 0, 32'h00000001, 1);
		op(iex_pkg::OP_SLT, 1, 1, 2, 9, 0, 32'h00000000, 1);
		op(iex_pkg::OP_LEADZ, 0, 5, 0, 9, 0, 32'h0000001B, 1);
		op(iex_pkg::OP_LEADO, 0, 11, 0, 9, 0, 32'h00000001, 1);
		op(iex_pkg::OP_LEADZ, 0, 0, 0, 9, 0, 32'h00000020, 1);
		op(iex_pkg::OP_LEADO, 0, 1, 0, 9, 0, 32'h00000020, 1);
		drain();
	endtask
	// a write to the shadow set leaves the main set alone
	task automatic shadowSeq();
		op(iex_pkg::OP_ADD, 0, 0, 0, 2, 1, 32'h00000000, 1);
		op(iex_pkg::OP_ADD, 0, 2, 0, 13, 0, 32'h00000001, 1);
		op(iex_pkg::OP_ADD, 0, 2, 0, 13, 1, 32'h00000000, 1);
		drain();
	endtask
	// pair ops: short and full right operands, accumulate, deduct with borrow
	task automatic pairSeq();
		prodOp(iex_pkg::OP_MPAIR, 0, 5, 3);
		rd(iex_pkg::OP_RDBOTTOM, 32'h00000020, 1);
		prodOp(iex_pkg::OP_MACC, 0, 5, 3);
		prodOp(iex_pkg::OP_MDED, 0, 3, 3);
		rd(iex_pkg::OP_RDBOTTOM, 32'h0000003C, 1);
		rd(iex_pkg::OP_RDUPPER, 32'h00000000, 2);
		prodOp(iex_pkg::OP_MDED, 0, 5, 6);
		rd(iex_pkg::OP_RDBOTTOM, 32'hFFF0003C, 2);
		rd(iex_pkg::OP_RDUPPER, 32'hFFFFFFFF, 3);
		prodOp(iex_pkg::OP_MPAIR, 1, 1, 3);
		rd(iex_pkg::OP_RDUPPER, 32'h00000001, 1);
		prodOp(iex_pkg::OP_MPAIR, 0, 1, 3);
		rd(iex_pkg::OP_RDUPPER, 32'hFFFFFFFF, 1);
		prodOp(iex_pkg::OP_MPAIR, 0, 7, 6);
		t1 = t0;
		prodOp(iex_pkg::OP_MPAIR, 0, 7, 6);
		`CHK((t0 - t1) / 40, 2)
		rd(iex_pkg::OP_RDBOTTOM, 32'hFFFF0000, 2);
		rd(iex_pkg::OP_RDUPPER, 32'h00007FFF, 3);
		prodOp(iex_pkg::OP_MPAIR, 0, 5, 3);
		t1 = t0;
		prodOp(iex_pkg::OP_MPAIR, 0, 5, 3);
		`CHK((t0 - t1) / 40, 1)
		drain();
	endtask
	// register multiply; the dependent add must wait for the product
	task automatic gprSeq();
		op(iex_pkg::OP_MGPR, 0, 5, 3, 10, 0, 32'h00000020, 2);
		op(iex_pkg::OP_MGPR, 0, 5, 6, 10, 0, 32'h00100000, 3);
		op(iex_pkg::OP_ADD, 0, 10, 0, 14, 0, 32'h00100000, 1);
		drain();
	endtask
	// divides of every dividend width; the read waits out the whole divide
	task automatic divSeq();
		logic [4:0]  dvd[5];
		logic [31:0] quo[5];
		logic [31:0] rem[5];
		int          lat[5];
		dvd = '{5'h05, 5'h08, 5'h06, 5'h07, 5'h01};
		quo = '{32'h00000008, 32'h00000080, 32'h00008000, 32'h3FFFFFFF, 32'h00000000};
		rem = '{32'h00000000, 32'h00000000, 32'h00000000, 32'h00000001, 32'hFFFFFFFF};
		lat = '{12, 19, 26, 33, 12};
		for (int i = 0; i < 5; i++) begin
			prodOp(iex_pkg::OP_DIV, 0, dvd[i], 3);
			rd(iex_pkg::OP_RDBOTTOM, quo[i], lat[i]);
			rd(iex_pkg::OP_RDUPPER, rem[i], lat[i] + 1);
		end
		prodOp(iex_pkg::OP_DIV, 1, 8, 3);
		t1 = t0;
		prodOp(iex_pkg::OP_MPAIR, 0, 5, 3);
		`CHK((t0 - t1) / 40, 18)
		rd(iex_pkg::OP_RDBOTTOM, 32'h00000020, 1);
		drain();
	endtask
	// ----------------------------------------
	// verdict, watchdog and main sequence
	// ----------------------------------------
	task automatic closeOut();
		if (errTotal == 0 && numChecks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// the whole run needs a few hundred clocks; this span is far above it
	initial begin
		#(3000 * 40);
		errTotal++;
		closeOut();
	end
	initial begin
		resetn = 1'b0;
		errTotal = 0;
		numChecks = 0;
		repeat (5) @(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
		`CHK(wbValid, 1'b0)
		aluSeq();
		shadowSeq();
		pairSeq();
		gprSeq();
		divSeq();
		closeOut();
	end
endmodule

// file: pipe_issuer.sv
// Purpose: integer pipeline model that feeds requests to the execution block
// Assumes: issue is entered at a rising edge of ref_clk
// Notes:   a request stands unchanged until the edge that takes it
module pipe_issuer (
	input  wire logic    ref_clk,
	input  wire logic    stall,
	output logic         opValid,
	output iex_pkg::op_t opCode,
	output logic         opUnsigned,
	output logic [4:0]   srcA,
	output logic [4:0]   srcB,
	output logic [4:0]   dest,
	output logic         shadowSel
);
	timeunit 1ns;
	timeprecision 1ps;
	time lastTake; // edge at which the last request was taken
	// ----------------------------------------
	// idle request lines at time zero
	// ----------------------------------------
	initial begin
		opValid = 1'b0;
		opCode = iex_pkg::OP_NOP;
		opUnsigned = 1'b0;
		srcA = 5'h00;
		srcB = 5'h00;
		dest = 5'h00;
		shadowSel = 1'b0;
		lastTake = 0;
	end
	// ----------------------------------------
	// drive one request and hold it while refused
	// ----------------------------------------
	task automatic issue(input iex_pkg::op_t c, input logic u, input logic [4:0] a, b, d,
		input logic sh);
		int n;
		opValid <= 1'b1;
		opCode <= c;
		opUnsigned <= u;
		srcA <= a;
		srcB <= b;
		dest <= d;
		shadowSel <= sh;
		@(posedge ref_clk);
		// bounded so a stuck stall shows up as a late take, not a hang
		for (n = 0; stall !== 1'b0 && n < 60; n++) begin
			@(posedge ref_clk);
		end
		lastTake = $time;
	endtask
	// drop the request; one edge passes so a new one never lands in the same step
	task automatic idle();
		opValid <= 1'b0;
		@(posedge ref_clk);
	endtask
endmodule
